// File: tb/msss_hall_model.sv
// Hall sensor model: steps the three phase signals one state per request.
// Assumes step requests are raised and dropped at falling clock edges.
`timescale 1ns/10ps

module msss_hall_model (
   // Clock.
   input wire logic sys_clk,
   // Step request and sense of the step.
   input wire logic step,
   input wire logic fwd,
   // Sensor outputs, always driven as real sensors are.
   output msss_pkg::msss_hall_type hall
);
   logic [2:0] idx_reg = 3'h0;
   logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

   assign hall = seq[idx_reg];

   always @(posedge sys_clk) begin
      if (step) begin
         if (fwd) begin
            idx_reg <= (idx_reg == 3'h5) ? 3'h0 : idx_reg + 3'h1;
         end else begin
            idx_reg <= (idx_reg == 3'h0) ? 3'h5 : idx_reg - 3'h1;
         end
      end
   end
endmodule : msss_hall_model

// File: tb/msss_sequencer_assertions.sv
// Port checker for the sequencer, bound into every sequencer instance.
// Assumes the single sys_clk domain and the asynchronous rst_n.
`timescale 1ns/10ps

module msss_sequencer_assertions #(
   parameter int CHARGE_CYCLES = msss_pkg::CHARGE_CYCLES,
   parameter int HALL_TIMEOUT_CYCLES = msss_pkg::HALL_TIMEOUT_CYCLES,
   parameter int LOCK_DETECT_CYCLES = msss_pkg::LOCK_DETECT_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Inputs watched.
   input wire logic [6:0] speed_command_voltage,
   input wire logic rotation_direction_select,
   // Outputs watched.
   input wire msss_pkg::msss_gate_type gate_drive,
   input wire msss_pkg::msss_state_type seq_state,
   input wire logic sine_mode,
   input wire logic test_mode,
   input wire logic lock_fault,
   input wire logic reverse_detected,
   input wire logic direction_forward,
   input wire logic thermal_shutdown_enable,
   input wire logic phase_advance_zero,
   input wire logic [6:0] duty_code
);
   wire logic [6:0] spd;
   wire logic [6:0] exp_duty;
   assign spd = speed_command_voltage;
   assign exp_duty = (spd < msss_pkg::SPEED_DRIVE_CODE) ? 7'h00 :
      (spd >= msss_pkg::SPEED_FULL_CODE) ? msss_pkg::DUTY_SPAN_CODE :
      spd - msss_pkg::SPEED_DRIVE_CODE;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_all_off;
      gate_drive == 6'h00;
   endsequence
   sequence s_charge_hold;
      (gate_drive == 6'h15 || seq_state == msss_pkg::SEQ_DRIVE) [*8];
   endsequence

   a_off_gates_quiet: assert property (
      seq_state == msss_pkg::SEQ_OFF |-> s_all_off)
      else $error("gates active in off state");
   a_charge_low_only: assert property (
      seq_state == msss_pkg::SEQ_CHARGE |-> gate_drive inside {6'h00, 6'h15})
      else $error("charge pattern wrong");
   a_charge_pulse_held: assert property (
      seq_state == msss_pkg::SEQ_CHARGE &&
      $past(seq_state, 2) == msss_pkg::SEQ_CHARGE &&
      $rose(gate_drive.u_lo) |=> s_charge_hold)
      else $error("charge pulse too short");
   a_drive_state_kept: assert property (
      seq_state == msss_pkg::SEQ_DRIVE |=> seq_state == msss_pkg::SEQ_DRIVE)
      else $error("left drive state");
   a_charge_no_back: assert property (
      seq_state == msss_pkg::SEQ_CHARGE |=> seq_state != msss_pkg::SEQ_OFF)
      else $error("charge fell back to off");
   a_duty_follows: assert property (
      seq_state == msss_pkg::SEQ_DRIVE |=> duty_code == $past(exp_duty))
      else $error("duty code wrong");
   a_reverse_trap_only: assert property (
      reverse_detected |-> !sine_mode)
      else $error("sine kept while reversed");
   a_test_mode_outputs: assert property (
      thermal_shutdown_enable == !test_mode && phase_advance_zero == test_mode)
      else $error("test mode outputs wrong");
   a_test_high_full: assert property (
      test_mode && $past(seq_state) == msss_pkg::SEQ_DRIVE &&
      !$past(sine_mode) &&
      (gate_drive.u_lo || gate_drive.v_lo || gate_drive.w_lo)
      |-> (gate_drive.u_hi || gate_drive.v_hi || gate_drive.w_hi))
      else $error("test mode high side not full");
   a_lock_fault_sticky: assert property (
      lock_fault |=> lock_fault && gate_drive == 6'h00)
      else $error("lock fault not held");
   a_dir_follows_pin: assert property (
      $changed(rotation_direction_select)
      |-> ##[1:4] direction_forward == rotation_direction_select)
      else $error("direction not followed");
endmodule : msss_sequencer_assertions

bind msss_sequencer msss_sequencer_assertions #(
   .CHARGE_CYCLES(CHARGE_CYCLES),
   .HALL_TIMEOUT_CYCLES(HALL_TIMEOUT_CYCLES),
   .LOCK_DETECT_CYCLES(LOCK_DETECT_CYCLES)
) u_msss_chk (
   .sys_clk, .rst_n, .speed_command_voltage, .rotation_direction_select,
   .gate_drive, .seq_state, .sine_mode, .test_mode, .lock_fault,
   .reverse_detected, .direction_forward, .thermal_shutdown_enable,
   .phase_advance_zero, .duty_code);

// File: tb/msss_sequencer_tb.sv
// Self-checking bench for the startup and speed sequencer.
// Assumes the package, Hall model and bound checker are compiled first.
`timescale 1ns/10ps

module msss_sequencer_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] speed = 7'h00;
   logic [6:0] lead = 7'h00;
   logic dir_sel = 1'b1;
   logic lock_sel = 1'b1;
   logic step = 1'b0;
   logic step_fwd = 1'b1;
   msss_pkg::msss_hall_type hall;
   msss_pkg::msss_gate_type gate_drive;
   msss_pkg::msss_state_type seq_state;
   logic sine_mode, test_mode, lock_fault, reverse_detected;
   logic direction_forward, lock_protect_enable;
   logic thermal_shutdown_enable, phase_advance_zero;
   logic [6:0] duty_code;
   logic [6:0] spds [5] = '{7'h1b, 7'h28, 7'h45, 7'h46, 7'h7f};
   logic [6:0] duties [5] = '{7'h00, 7'h0d, 7'h2a, 7'h2b, 7'h2b};
   int mismatches = 0;
   int checked = 0;

   always #10 sys_clk = ~sys_clk;

   msss_sequencer #(.CHARGE_CYCLES(200), .HALL_TIMEOUT_CYCLES(2000),
      .LOCK_DETECT_CYCLES(5000)) DUT (
      .sys_clk, .rst_n, .speed_command_voltage(speed),
      .lead_angle_voltage(lead), .position_sense_signal(hall),
      .rotation_direction_select(dir_sel), .lock_protect_select(lock_sel),
      .gate_drive, .seq_state, .sine_mode, .test_mode, .lock_fault,
      .reverse_detected, .direction_forward, .lock_protect_enable,
      .thermal_shutdown_enable, .phase_advance_zero, .duty_code);

   msss_hall_model u_hall (.sys_clk, .step, .fwd(step_fwd), .hall);

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_cyc

   task automatic chk(input string what, input logic [6:0] exp,
      input logic [6:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic summarize;
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   // Straps are set while reset is held, with the speed command set first.
   task automatic power_up(input logic [6:0] spd, input logic [6:0] ld,
      input logic lsel);
      rst_n = 1'b0;
      speed = spd;
      lead = ld;
      lock_sel = lsel;
      dir_sel = 1'b1;
      wait_cyc(3);
      rst_n = 1'b1;
      wait_cyc(8);
   endtask : power_up

   task automatic do_step(input logic fwd);
      step_fwd = fwd;
      step = 1'b1;
      wait_cyc(1);
      step = 1'b0;
      wait_cyc(6);
   endtask : do_step

   function automatic logic [5:0] exp_gate(input logic [2:0] c,
      input logic fwd);
      logic [2:0] k;
      k = fwd ? c : ~c;
      case (k)
         3'h5: return 6'h18;
         3'h4: return 6'h12;
         3'h6: return 6'h06;
         3'h2: return 6'h24;
         3'h3: return 6'h21;
         3'h1: return 6'h09;
         default: return 6'h00;
      endcase
   endfunction : exp_gate

   task automatic walk(input logic fwd, input int n);
      for (int i = 0; i < n; i++) begin
         do_step(fwd);
         chk("gates", {1'b0, exp_gate(hall, dir_sel)},
            {1'b0, gate_drive});
      end
   endtask : walk

   initial begin
      power_up(7'h00, 7'h00, 1'b1);
      chk("dir", 7'h01, {6'h00, direction_forward});
      chk("lock_en", 7'h00, {6'h00, lock_protect_enable});
      speed = 7'h0c;
      wait_cyc(10);
      chk("state", 7'h01, {4'h0, seq_state});
      chk("gates", 7'h00, {1'b0, gate_drive});
      speed = 7'h0d;
      for (int n = 0; n < 2600 && gate_drive.u_lo !== 1'b1; n++) begin
         wait_cyc(1);
      end
      chk("state", 7'h02, {4'h0, seq_state});
      chk("gates", 7'h15, {1'b0, gate_drive});
      wait_cyc(300);
      chk("gates", 7'h00, {1'b0, gate_drive});
      power_up(7'h00, 7'h00, 1'b1);
      speed = 7'h28;
      wait_cyc(150);
      chk("state", 7'h02, {4'h0, seq_state});
      wait_cyc(110);
      chk("state", 7'h04, {4'h0, seq_state});
      for (int i = 0; i < 5; i++) begin
         speed = spds[i];
         wait_cyc(4);
         chk("duty", duties[i], duty_code);
      end
      speed = 7'h46;
      walk(1'b1, 6);
      chk("sine", 7'h01, {6'h00, sine_mode});
      do_step(1'b0);
      chk("reverse", 7'h01, {6'h00, reverse_detected});
      chk("sine", 7'h00, {6'h00, sine_mode});
      dir_sel = 1'b0;
      wait_cyc(5);
      chk("dir", 7'h00, {6'h00, direction_forward});
      walk(1'b0, 6);
      chk("sine", 7'h01, {6'h00, sine_mode});
      wait_cyc(2100);
      chk("sine", 7'h00, {6'h00, sine_mode});
      power_up(7'h00, 7'h00, 1'b1);
      do_step(1'b0);
      do_step(1'b0);
      speed = 7'h28;
      wait_cyc(5);
      chk("state", 7'h04, {4'h0, seq_state});
      power_up(7'h68, 7'h46, 1'b1);
      chk("test", 7'h01, {6'h00, test_mode});
      chk("tsd_en", 7'h00, {6'h00, thermal_shutdown_enable});
      chk("adv0", 7'h01, {6'h00, phase_advance_zero});
      speed = 7'h28;
      wait_cyc(2100);
      walk(1'b1, 1);
      for (int i = 0; i < 4; i++) begin
         wait_cyc(600);
         chk("gates", {1'b0, exp_gate(hall, 1'b1)},
            {1'b0, gate_drive});
      end
      power_up(7'h00, 7'h00, 1'b0);
      chk("lock_en", 7'h01, {6'h00, lock_protect_enable});
      speed = 7'h28;
      wait_cyc(5200);
      chk("lock", 7'h01, {6'h00, lock_fault});
      chk("gates", 7'h00, {1'b0, gate_drive});
      summarize();
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end
endmodule : msss_sequencer_tb

// File: verilog/msss_pkg.sv
// Constants and types for the motor startup and speed sequencer.
// Assumes a 50 MHz sys_clk and a 7-bit speed command code on a 0-10 V scale.
//
// Functional notes
// - Capture lock and direction selects before acting.
// - Command below 1.0 V level: all gates off.
// - Charging band: low sides pulse every PWM period.
// - Drive band: duty rises with command value.
// - Slow position sense: six-step trapezoidal drive.
// - Position sense 1.0 Hz or more: sinusoidal drive.
// - Forward Hall code to gate mapping table.
// - Reverse uses forward table on inverted code.
// - Wrong-way rotation forces trapezoidal drive at once.
// - Skip charging when reversed or coasting fast.
// - Direct jump to drive: charge 9 ms first.
// - Duty derived from 7-bit command code only.
// - Command at 5.5 V level or more: full duty.
// - Test mode: full high side in trapezoidal drive, no shutdown, zero advance.
// - Test mode only if straps set at power-up.
// - No Hall change within lock time: lock fault.
// - Direction low reverse, high forward, kept monitored.
// - Lock select low enables, high disables protection.

package msss_pkg;

   // ***************************************************
   // Speed command and lead-angle thresholds, and the duty span, as 7-bit codes.
   // ***************************************************
   localparam logic [6:0] SPEED_OFF_CODE = 7'h0d;
   localparam logic [6:0] SPEED_DRIVE_CODE = 7'h1b;
   localparam logic [6:0] SPEED_FULL_CODE = 7'h46;
   localparam logic [6:0] SPEED_TEST_CODE = 7'h68;
   localparam logic [6:0] DUTY_SPAN_CODE = 7'h2b;
   localparam logic [6:0] LEAD_TEST_LOW_CODE = 7'h42;
   localparam logic [6:0] LEAD_TEST_HIGH_CODE = 7'h4a;

   // ***************************************************
   // Timing.
   // ***************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int PWM_PERIOD_NS = 50000;
   localparam int PWM_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CHARGE_PULSE_NS = 5000;
   localparam int CHARGE_PULSE_CYCLES = CHARGE_PULSE_NS / CLK_PERIOD_NS;
   localparam int CHARGE_TIME_US = 9000;
   localparam int CHARGE_CYCLES = CHARGE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int HALL_TIMEOUT_MS = 1000;
   localparam int HALL_TIMEOUT_CYCLES =
      HALL_TIMEOUT_MS * 1000 / CLK_PERIOD_NS * 1000;
   localparam int LOCK_DETECT_MS = 1000;
   localparam int LOCK_DETECT_CYCLES =
      LOCK_DETECT_MS * 1000 / CLK_PERIOD_NS * 1000;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   // ***************************************************
   // Types.
   // ***************************************************
   typedef enum logic [2:0] {
      SEQ_OFF = 3'b001,
      SEQ_CHARGE = 3'b010,
      SEQ_DRIVE = 3'b100
   } msss_state_type;

   typedef struct packed {
      logic u_hi;
      logic u_lo;
      logic v_hi;
      logic v_lo;
      logic w_hi;
      logic w_lo;
   } msss_gate_type;

   typedef struct packed {
      logic hall_phase_a;
      logic hall_phase_b;
      logic hall_phase_c;
   } msss_hall_type;

endpackage : msss_pkg

// File: verilog/msss_sequencer.sv
// Startup and speed sequencer for a Hall-sensed three-phase driver.
// Assumes speed and lead-angle codes come from on-clock converters and that
// rst_n is the supply-threshold power-on reset.
`timescale 1ns/10ps

module msss_sequencer #(
   parameter int CHARGE_CYCLES = msss_pkg::CHARGE_CYCLES,
   parameter int HALL_TIMEOUT_CYCLES = msss_pkg::HALL_TIMEOUT_CYCLES,
   parameter int LOCK_DETECT_CYCLES = msss_pkg::LOCK_DETECT_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Converted analogue inputs.
   input wire logic [6:0] speed_command_voltage,
   input wire logic [6:0] lead_angle_voltage,
   // Pin inputs.
   input wire msss_pkg::msss_hall_type position_sense_signal,
   input wire logic rotation_direction_select,
   input wire logic lock_protect_select,
   // Gate drive.
   output msss_pkg::msss_gate_type gate_drive,
   // Status.
   output msss_pkg::msss_state_type seq_state,
   output logic sine_mode,
   output logic test_mode,
   output logic lock_fault,
   output logic reverse_detected,
   output logic direction_forward,
   output logic lock_protect_enable,
   output logic thermal_shutdown_enable,
   output logic phase_advance_zero,
   output logic [6:0] duty_code
);

   // ***************************************************
   // Helpers.
   // ***************************************************
   function automatic logic [5:0] commutate(input logic [2:0] code);
      logic [5:0] g;
      g = 6'h00;
      case (code)
         3'b101: g = 6'b011000;
         3'b100: g = 6'b010010;
         3'b110: g = 6'b000110;
         3'b010: g = 6'b100100;
         3'b011: g = 6'b100001;
         3'b001: g = 6'b001001;
         default: g = 6'h00;
      endcase
      return g;
   endfunction : commutate

   function automatic logic [2:0] hall_index(input logic [2:0] code);
      logic [2:0] i;
      i = 3'h7;
      case (code)
         3'b101: i = 3'h0;
         3'b100: i = 3'h1;
         3'b110: i = 3'h2;
         3'b010: i = 3'h3;
         3'b011: i = 3'h4;
         3'b001: i = 3'h5;
         default: i = 3'h7;
      endcase
      return i;
   endfunction : hall_index

   // ***************************************************
   // Input synchronisers.
   // ***************************************************
   logic [4:0] pins_sync;

   msss_sync #(.WIDTH(5)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in({position_sense_signal, rotation_direction_select,
               lock_protect_select}),
      .sync_out(pins_sync)
   );

   wire [2:0] hall_code = pins_sync[4:2];
   wire dir_sync = pins_sync[1];
   wire lock_sel_sync = pins_sync[0];

   // ***************************************************
   // Registers.
   // ***************************************************
   msss_pkg::msss_state_type state_reg, state_next;
   logic [1:0] settle_reg;
   logic captured_reg;
   logic dir_reg;
   logic lock_en_reg;
   logic test_reg;
   logic [2:0] hall_prev_reg;
   logic [25:0] edge_cnt_reg;
   logic fast_reg;
   logic sine_reg;
   logic reverse_reg;
   logic [25:0] lock_cnt_reg;
   logic lock_fault_reg;
   logic [18:0] charge_cnt_reg;
   logic [11:0] pwm_cnt_reg;
   msss_pkg::msss_gate_type gate_reg, gate_next;
   logic [6:0] duty_reg;

   // ***************************************************
   // Decode.
   // ***************************************************
   wire speed_off = speed_command_voltage < msss_pkg::SPEED_OFF_CODE;
   wire speed_drive = speed_command_voltage >= msss_pkg::SPEED_DRIVE_CODE;
   wire speed_full = speed_command_voltage >= msss_pkg::SPEED_FULL_CODE;
   wire hall_edge = hall_code != hall_prev_reg;
   wire [2:0] idx_now = hall_index(hall_code);
   wire [2:0] idx_prev = hall_index(hall_prev_reg);
   wire [2:0] idx_prev_next = (idx_prev == 3'h5) ? 3'h0 : idx_prev + 3'h1;
   wire [2:0] idx_now_next = (idx_now == 3'h5) ? 3'h0 : idx_now + 3'h1;
   wire codes_valid = idx_now != 3'h7 && idx_prev != 3'h7;
   wire step_fwd = hall_edge && codes_valid && idx_now == idx_prev_next;
   wire step_rev = hall_edge && codes_valid && idx_prev == idx_now_next;
   wire wrong_way = dir_reg ? step_rev : step_fwd;
   wire right_way = dir_reg ? step_fwd : step_rev;
   wire edge_timeout = edge_cnt_reg >= 26'(HALL_TIMEOUT_CYCLES);
   wire skip_charge = reverse_reg || fast_reg;
   wire charge_done = charge_cnt_reg >= 19'(CHARGE_CYCLES);
   wire lock_expired = lock_cnt_reg >= 26'(LOCK_DETECT_CYCLES);
   wire test_strap = speed_command_voltage >= msss_pkg::SPEED_TEST_CODE &&
      lead_angle_voltage >= msss_pkg::LEAD_TEST_LOW_CODE &&
      lead_angle_voltage <= msss_pkg::LEAD_TEST_HIGH_CODE;
   wire pwm_wrap = pwm_cnt_reg == 12'(msss_pkg::PWM_CYCLES - 1);
   wire charge_pulse = pwm_cnt_reg < 12'(msss_pkg::CHARGE_PULSE_CYCLES);
   wire [6:0] duty_excess = speed_drive ?
      7'(speed_command_voltage - msss_pkg::SPEED_DRIVE_CODE) : 7'h00;
   wire [19:0] duty_lhs = 20'(pwm_cnt_reg) *
      20'(msss_pkg::DUTY_SPAN_CODE);
   wire [19:0] duty_rhs = 20'(duty_excess) * 20'(msss_pkg::PWM_CYCLES);
   wire pwm_on = speed_full || duty_lhs < duty_rhs;
   wire [2:0] comm_code = dir_reg ? hall_code : ~hall_code;
   wire [5:0] comm_gates = commutate(comm_code);
   wire high_full = test_reg && !sine_reg;

   // ***************************************************
   // Startup state machine.
   // ***************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         msss_pkg::SEQ_OFF: begin
            if (captured_reg && !speed_off) begin
               if (!skip_charge) begin
                  state_next = msss_pkg::SEQ_CHARGE;
               end else if (speed_drive) begin
                  state_next = msss_pkg::SEQ_DRIVE;
               end
            end
         end
         msss_pkg::SEQ_CHARGE: begin
            if (speed_drive && charge_done) begin
               state_next = msss_pkg::SEQ_DRIVE;
            end
         end
         msss_pkg::SEQ_DRIVE: state_next = msss_pkg::SEQ_DRIVE;
         default: state_next = msss_pkg::SEQ_OFF;
      endcase
   end

   // ***************************************************
   // Gate selection.
   // ***************************************************
   always_comb begin
      gate_next = '0;
      if (speed_off || lock_fault_reg) begin
         gate_next = '0;
      end else if (state_reg == msss_pkg::SEQ_CHARGE) begin
         gate_next.u_lo = charge_pulse;
         gate_next.v_lo = charge_pulse;
         gate_next.w_lo = charge_pulse;
      end else if (state_reg == msss_pkg::SEQ_DRIVE && speed_drive) begin
         gate_next = comm_gates;
         gate_next.u_hi = comm_gates[5] && (pwm_on || high_full);
         gate_next.v_hi = comm_gates[3] && (pwm_on || high_full);
         gate_next.w_hi = comm_gates[1] && (pwm_on || high_full);
      end
   end

   // ***************************************************
   // Settings capture and Hall tracking.
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_reg <= 2'h0;
         captured_reg <= 1'b0;
         dir_reg <= 1'b1;
         lock_en_reg <= 1'b0;
         test_reg <= 1'b0;
      end else begin
         if (!captured_reg) begin
            settle_reg <= settle_reg + 2'h1;
            if (settle_reg == msss_pkg::SETTLE_CYCLES) begin
               captured_reg <= 1'b1;
               lock_en_reg <= !lock_sel_sync;
               test_reg <= test_strap;
            end
         end
         dir_reg <= dir_sync;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hall_prev_reg <= 3'h0;
         edge_cnt_reg <= 26'h000_0000;
         fast_reg <= 1'b0;
         sine_reg <= 1'b0;
         reverse_reg <= 1'b0;
      end else begin
         hall_prev_reg <= hall_code;
         if (hall_edge) begin
            edge_cnt_reg <= 26'h000_0000;
            fast_reg <= !edge_timeout && codes_valid;
         end else if (!edge_timeout) begin
            edge_cnt_reg <= edge_cnt_reg + 26'h000_0001;
         end else begin
            fast_reg <= 1'b0;
         end
         if (wrong_way) begin
            reverse_reg <= 1'b1;
         end else if (right_way) begin
            reverse_reg <= 1'b0;
         end
         if (wrong_way || reverse_reg || edge_timeout) begin
            sine_reg <= 1'b0;
         end else if (right_way && fast_reg && !edge_timeout) begin
            sine_reg <= 1'b1;
         end
      end
   end

   // ***************************************************
   // Timers, lock detection and outputs.
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= msss_pkg::SEQ_OFF;
         charge_cnt_reg <= 19'h0_0000;
         pwm_cnt_reg <= 12'h000;
         lock_cnt_reg <= 26'h000_0000;
         lock_fault_reg <= 1'b0;
         gate_reg <= '0;
         duty_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         pwm_cnt_reg <= pwm_wrap ? 12'h000 : pwm_cnt_reg + 12'h001;
         if (state_reg != msss_pkg::SEQ_CHARGE) begin
            charge_cnt_reg <= 19'h0_0000;
         end else if (!charge_done) begin
            charge_cnt_reg <= charge_cnt_reg + 19'h0_0001;
         end
         if (hall_edge) begin
            lock_cnt_reg <= 26'h000_0000;
         end else if (!lock_expired) begin
            lock_cnt_reg <= lock_cnt_reg + 26'h000_0001;
         end
         if (captured_reg && lock_en_reg && lock_expired) begin
            lock_fault_reg <= 1'b1;
         end
         gate_reg <= gate_next;
         duty_reg <= speed_full ? msss_pkg::DUTY_SPAN_CODE : duty_excess;
      end
   end

   assign gate_drive = gate_reg;
   assign seq_state = state_reg;
   assign sine_mode = sine_reg;
   assign test_mode = test_reg;
   assign lock_fault = lock_fault_reg;
   assign reverse_detected = reverse_reg;
   assign direction_forward = dir_reg;
   assign lock_protect_enable = lock_en_reg;
   assign thermal_shutdown_enable = !test_reg;
   assign phase_advance_zero = test_reg;
   assign duty_code = duty_reg;

endmodule : msss_sequencer

// File: verilog/msss_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous levels; output resets to zero.
`timescale 1ns/10ps

module msss_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Pin side and synchronised side.
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule : msss_sync
